/* File: core/bcw_pkg.sv */
// package: constants, encodings and carrier types for the board
// control bank (special control, watchdog refresh, fan monitor).
// assumes a single 40 MHz clock and word-wide ahb-lite access.
package bcw_pkg;

  // clock and timing figures
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned WDOG_PERIOD_MS  = 1000;
  localparam int unsigned WDOG_CYCLES     = CLK_HZ / 1000 * WDOG_PERIOD_MS;
  localparam int unsigned FAN_MIN_HZ      = 1;
  localparam int unsigned FAN_CYCLES      = CLK_HZ / FAN_MIN_HZ;
  localparam int unsigned CNT_W           = 26;

  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_SPC         = 12'hCA2;
  localparam logic [11:0] IDX_REFRESH     = 12'hCA3;
  localparam logic [11:0] IDX_FAN         = 12'hCA4;
  localparam logic [11:0] IDX_ISTAT       = 12'hCA6;
  localparam logic [11:0] IDX_IMASK       = 12'hCA7;
  localparam logic [11:0] ALT_BASE_DELTA  = 12'h010;
  localparam int unsigned IDX_LSB         = 2;
  localparam int unsigned IDX_MSB         = 13;

  // special control field positions
  localparam int unsigned SPC_JMP_BIT     = 7;
  localparam int unsigned SPC_OVR_BIT     = 6;
  localparam int unsigned SPC_SEL_BIT     = 5;
  localparam int unsigned SPC_MODE_HI     = 4;
  localparam int unsigned SPC_MODE_LO     = 3;
  localparam int unsigned SPC_WST_BIT     = 2;
  localparam int unsigned SPC_WEN_BIT     = 1;

  // fan monitor control field positions
  localparam int unsigned FAN_SLOW_BIT    = 7;
  localparam int unsigned FAN_IE_BIT      = 0;

  // refresh key and line mode encodings
  localparam logic [7:0] REFRESH_KEY      = 8'h5A;
  localparam logic [1:0] MODE_RS232       = 2'h0;
  localparam logic [1:0] MODE_RS422       = 2'h1;
  localparam logic [1:0] MODE_RS485       = 2'h2;

  // interrupt events
  localparam int unsigned EV_WDOG         = 0;
  localparam int unsigned EV_FAN          = 1;
  localparam int unsigned N_EV            = 2;

  // reset values
  localparam logic        RST_OVR         = 1'b0;
  localparam logic        RST_SEL         = 1'b1;
  localparam logic [1:0]  RST_MODE        = MODE_RS232;
  localparam logic        RST_WEN         = 1'b0;
  localparam logic        RST_FAN_IE      = 1'b0;
  localparam logic [N_EV-1:0] RST_EV      = 2'h0;
  localparam logic [31:0] RDATA_ZERO      = 32'h0000_0000;
  localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;

  typedef enum logic [2:0] {
    SEL_NONE, SEL_SPC, SEL_REFRESH, SEL_FAN, SEL_ISTAT, SEL_IMASK
  } bcw_reg_sel_type;

  // accepted address phase carried into the data phase
  typedef struct packed {
    logic            valid;
    logic            write;
    bcw_reg_sel_type sel;
  } bcw_addr_phase_type;

  // software-owned special control fields
  typedef struct packed {
    logic       firmware_override;
    logic       firmware_image_select;
    logic [1:0] serial_line_mode;
    logic       watchdog_reset_enable;
  } bcw_spc_ctrl_type;

endpackage

/* File: core/bcw_watchdog.sv */
// watchdog timer: counts while enabled, restarts on a keyed refresh.
// assumes refresh is a one-cycle pulse already checked against the key.
`timescale 1ns/1ps
module bcw_watchdog import bcw_pkg::*; #(
  parameter int unsigned PERIOD = WDOG_CYCLES
) (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic hce,
  // control
  input  wire logic enable,
  input  wire logic refresh,
  // status
  output logic      expired,
  output logic      expire_pulse
);

  typedef enum logic [1:0] {WD_IDLE, WD_COUNT, WD_EXPIRED} bcw_wd_state_type;

  bcw_wd_state_type   state_q, state_d;
  logic [CNT_W-1:0]   count_q, count_d;
  logic               expired_q;
  logic               hit_end;

  assign hit_end = (count_q == CNT_W'(PERIOD - 1));
  assign expire_pulse = (state_q == WD_COUNT) && enable && hit_end && !refresh;
  assign expired = expired_q;

  // next state; a refresh always restarts the period from zero
  always_comb begin
    state_d = state_q;
    count_d = count_q;
    unique case (state_q)
      WD_IDLE: begin
        count_d = '0;
        if (enable) state_d = WD_COUNT;
      end
      WD_COUNT: begin
        if (!enable) begin
          state_d = WD_IDLE;
          count_d = '0;
        end else if (refresh) begin
          count_d = '0;
        end else if (hit_end) begin
          state_d = WD_EXPIRED;
        end else begin
          count_d = count_q + CNT_W'(1);
        end
      end
      WD_EXPIRED: begin
        count_d = '0;
        if (!enable) state_d = WD_IDLE;
        else if (refresh) state_d = WD_COUNT;
      end
    endcase
  end

  // flag stays until a keyed refresh; a refresh in the same cycle wins over expiry
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q   <= WD_IDLE;
      count_q   <= '0;
      expired_q <= 1'b0;
    end else if (hce) begin
      state_q   <= state_d;
      count_q   <= count_d;
      expired_q <= expire_pulse | (expired_q & ~refresh);
    end
  end

endmodule

/* File: core/bcw_fan_monitor.sv */
// fan monitor: measures time between tachometer rising edges and
// flags a fan slower than the minimum rate.
// assumes the tach input is already synchronous to hclk.
`timescale 1ns/1ps
module bcw_fan_monitor import bcw_pkg::*; #(
  parameter int unsigned LIMIT = FAN_CYCLES
) (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic hce,
  // tachometer
  input  wire logic fan_tach,
  // status
  output logic      fan_slow,
  output logic      slow_pulse
);

  logic [CNT_W-1:0] gap_q;
  logic             tach_q;
  logic             slow_q;
  logic             tach_edge;
  logic             gap_full;

  assign tach_edge  = fan_tach & ~tach_q;
  assign gap_full   = (gap_q == CNT_W'(LIMIT - 1));
  assign slow_pulse = gap_full & ~tach_edge & ~slow_q;
  assign fan_slow   = slow_q;

  // gap counter saturates; no edge for a whole second means too slow
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tach_q <= 1'b0;
      gap_q  <= '0;
      slow_q <= 1'b0;
    end else if (hce) begin
      tach_q <= fan_tach;
      if (tach_edge) gap_q <= '0;
      else if (!gap_full) gap_q <= gap_q + CNT_W'(1);
      if (tach_edge) slow_q <= 1'b0;
      else if (gap_full) slow_q <= 1'b1;
    end
  end

endmodule

/* File: core/bcw_board_ctrl.sv */
// board control bank: special control, watchdog refresh and fan
// monitor control behind an ahb-lite slave, plus interrupt status.
// assumes one ahb-lite master doing word transfers on hclk.
`timescale 1ns/1ps

// Operation
// - jumper state read back, 0 fitted
// - override set: select bit chooses image
// - select 0 backup, 1 primary
// - two-bit serial line mode field drives port
// - read-only watchdog expired status bit
// - enable bit turns watchdog on
// - special control bit zero does nothing
// - writing 5Ah restarts watchdog period
// - slow-fan flag when tach below 1 Hz
// - fan interrupt enable gates fan interrupt
// - fan register bits six..one do nothing
// - bank decoded at primary and alternate base
module bcw_board_ctrl import bcw_pkg::*; #(
  parameter int unsigned WDOG_CYCLES_P = WDOG_CYCLES,
  parameter int unsigned FAN_CYCLES_P  = FAN_CYCLES
) (
  // clock, reset, clock enable
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hce,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // board straps and controls
  input  wire logic        firmware_jumper_state,
  output logic             firmware_primary_sel,
  output logic [1:0]       serial_line_mode,
  output logic             sys_reset_req,
  // fan
  input  wire logic        fan_tach,
  output logic             fan_irq,
  // interrupt
  output logic             irq
);

  // map an index, at either base, onto a register select
  function automatic bcw_reg_sel_type decode_index(input logic [11:0] idx);
    logic [11:0] pri;
    pri = idx + ALT_BASE_DELTA;
    if (idx == IDX_SPC || pri == IDX_SPC) return SEL_SPC;
    if (idx == IDX_REFRESH || pri == IDX_REFRESH) return SEL_REFRESH;
    if (idx == IDX_FAN || pri == IDX_FAN) return SEL_FAN;
    if (idx == IDX_ISTAT || pri == IDX_ISTAT) return SEL_ISTAT;
    if (idx == IDX_IMASK || pri == IDX_IMASK) return SEL_IMASK;
    return SEL_NONE;
  endfunction

  // one byte aligned into a bus word, upper bits zero
  function automatic logic [31:0] widen(input logic [7:0] b);
    return {24'h00_0000, b};
  endfunction

  // bus state
  bcw_addr_phase_type ap_q, ap_d;
  logic               rd_ready_q;
  logic [31:0]        hrdata_q;

  // software state
  bcw_spc_ctrl_type   spc_q;
  logic               fan_ie_q;
  logic [N_EV-1:0]    istat_q;
  logic [N_EV-1:0]    imask_q;

  // block status
  logic               wd_expired;
  logic               wd_expire_pulse;
  logic               fan_slow;
  logic               fan_slow_pulse;

  // address phase decode
  logic               ap_take;
  logic               high_zero;
  bcw_reg_sel_type    ap_sel;
  logic [11:0]        ap_index;

  // data phase strobes
  logic               wr_fire;
  logic               rd_fire;
  logic               wr_spc;
  logic               wr_refresh;
  logic               wr_fan;
  logic               wr_istat;
  logic               wr_imask;
  logic               refresh_ok;
  logic [7:0]         wbyte;

  // read mux
  logic [7:0]         spc_rd;
  logic [7:0]         fan_rd;
  logic [7:0]         rd_byte;

  // interrupt events
  logic [N_EV-1:0]    ev;
  logic [N_EV-1:0]    istat_clr;

  // ---------------------------------------------------------------
  // ahb-lite address phase; a frozen clock enable stalls an open data phase, except a read past its wait state, and drops new transfers
  // ---------------------------------------------------------------

  // only indices with the top address bits zero count as a hit; haddr[1:0] is ignored
  assign ap_index  = haddr[IDX_MSB:IDX_LSB];
  assign high_zero = (haddr[31:IDX_MSB+1] == '0);
  assign ap_sel    = high_zero ? decode_index(ap_index) : SEL_NONE;
  assign ap_take   = hsel && (htrans == HTRANS_NONSEQ) && hready && hce;

  // next address phase record: replaced whenever the bus moves on
  always_comb begin
    ap_d = ap_q;
    if (hready && hce) begin
      ap_d.valid = ap_take;
      ap_d.write = hwrite;
      ap_d.sel   = ap_sel;
    end
  end

  // writes complete with no wait; reads wait one cycle so that the
  // read data always reflects a write that just finished
  assign hreadyout = !ap_q.valid ||
                     (ap_q.write ? hce : rd_ready_q);
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  // data phase strobes, qualified by the clock enable
  assign wr_fire    = ap_q.valid && ap_q.write && hce;
  assign rd_fire    = ap_q.valid && !ap_q.write && !rd_ready_q && hce;
  assign wbyte      = hwdata[7:0];
  assign wr_spc     = wr_fire && (ap_q.sel == SEL_SPC);
  assign wr_refresh = wr_fire && (ap_q.sel == SEL_REFRESH);
  assign wr_fan     = wr_fire && (ap_q.sel == SEL_FAN);
  assign wr_istat   = wr_fire && (ap_q.sel == SEL_ISTAT);
  assign wr_imask   = wr_fire && (ap_q.sel == SEL_IMASK);

  // only the exact key restarts the watchdog; anything else is dropped
  assign refresh_ok = wr_refresh && (wbyte == REFRESH_KEY);

  // bus pipeline registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_q       <= '{valid: 1'b0, write: 1'b0, sel: SEL_NONE};
      rd_ready_q <= 1'b0;
      hrdata_q   <= RDATA_ZERO;
    end else if (hce) begin
      ap_q       <= ap_d;
      rd_ready_q <= rd_fire;
      if (rd_fire) hrdata_q <= widen(rd_byte);
    end
  end

  // ---------------------------------------------------------------
  // register read view
  // ---------------------------------------------------------------

  // special control: bit zero always reads zero and holds nothing
  assign spc_rd = {firmware_jumper_state,
                   spc_q.firmware_override,
                   spc_q.firmware_image_select,
                   spc_q.serial_line_mode,
                   wd_expired,
                   spc_q.watchdog_reset_enable,
                   1'b0};

  // fan control: reserved middle bits read zero
  assign fan_rd = {fan_slow, 6'h00, fan_ie_q};

  // refresh register is write-only; unmapped indices read zero
  always_comb begin
    rd_byte = 8'h00;
    unique case (ap_q.sel)
      SEL_SPC:     rd_byte = spc_rd;
      SEL_FAN:     rd_byte = fan_rd;
      SEL_ISTAT:   rd_byte = {6'h00, istat_q};
      SEL_IMASK:   rd_byte = {6'h00, imask_q};
      SEL_REFRESH: rd_byte = 8'h00;
      SEL_NONE:    rd_byte = 8'h00;
      default:     rd_byte = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // software-written control
  // ---------------------------------------------------------------

  // special control write: read-only bits and bit zero are discarded
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      spc_q <= '{firmware_override:     RST_OVR,
                 firmware_image_select: RST_SEL,
                 serial_line_mode:      RST_MODE,
                 watchdog_reset_enable: RST_WEN};
    end else if (wr_spc) begin
      spc_q.firmware_override     <= wbyte[SPC_OVR_BIT];
      spc_q.firmware_image_select <= wbyte[SPC_SEL_BIT];
      spc_q.serial_line_mode      <= wbyte[SPC_MODE_HI:SPC_MODE_LO];
      spc_q.watchdog_reset_enable <= wbyte[SPC_WEN_BIT];
    end
  end

  // fan control write: only the enable bit is stored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fan_ie_q <= RST_FAN_IE;
    end else if (wr_fan) begin
      fan_ie_q <= wbyte[FAN_IE_BIT];
    end
  end

  // interrupt mask, same layout as the status register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      imask_q <= RST_EV;
    end else if (wr_imask) begin
      imask_q <= wbyte[N_EV-1:0];
    end
  end

  // ---------------------------------------------------------------
  // board outputs
  // ---------------------------------------------------------------

  // override replaces the jumper; 0 backup, 1 primary either way
  assign firmware_primary_sel = spc_q.firmware_override ?
                                spc_q.firmware_image_select :
                                firmware_jumper_state;

  // the reserved code is passed through; the transceiver owns it
  assign serial_line_mode = spc_q.serial_line_mode;

  // reset request holds while the expiry stands and the circuit is on
  assign sys_reset_req = wd_expired && spc_q.watchdog_reset_enable;

  // dedicated fan line follows the condition, not the sticky status
  assign fan_irq = fan_ie_q && fan_slow;

  // ---------------------------------------------------------------
  // watchdog and fan monitor
  // ---------------------------------------------------------------

  // the host must keep refreshing well inside the period
  bcw_watchdog #(
    .PERIOD (WDOG_CYCLES_P)
  ) u_watchdog (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .hce          (hce),
    .enable       (spc_q.watchdog_reset_enable),
    .refresh      (refresh_ok),
    .expired      (wd_expired),
    .expire_pulse (wd_expire_pulse)
  );

  bcw_fan_monitor #(
    .LIMIT (FAN_CYCLES_P)
  ) u_fan_monitor (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .hce        (hce),
    .fan_tach   (fan_tach),
    .fan_slow   (fan_slow),
    .slow_pulse (fan_slow_pulse)
  );

  // ---------------------------------------------------------------
  // sticky interrupt status, write one to clear
  // ---------------------------------------------------------------

  // slow-fan events only count while fan interrupts are enabled
  assign ev[EV_WDOG] = wd_expire_pulse;
  assign ev[EV_FAN]  = fan_slow_pulse && fan_ie_q;
  assign istat_clr   = wr_istat ? wbyte[N_EV-1:0] : RST_EV;

  // a new event in the clearing cycle wins, so none is lost
  generate
    for (genvar i = 0; i < N_EV; i++) begin : g_istat
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          istat_q[i] <= 1'b0;
        end else if (hce) begin
          istat_q[i] <= ev[i] | (istat_q[i] & ~istat_clr[i]);
        end
      end
    end
  endgenerate

  // level interrupt while any unmasked status bit stands
  assign irq = |(istat_q & imask_q);

endmodule

/* File: dv/bcw_board_ctrl_sva.sv */
// checker for the board control bank: bus timing, read-back fields,
// watchdog reset request release and fan interrupt release.
// assumes a single ahb-lite master; sees only the top module's ports.
`timescale 1ns/1ps
module bcw_board_ctrl_sva import bcw_pkg::*; #(
  parameter int unsigned WDOG_CYCLES_P = WDOG_CYCLES,
  parameter int unsigned FAN_CYCLES_P  = FAN_CYCLES
) (
  // clock, reset, clock enable
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hce,
  // ahb-lite slave
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // board pins
  input wire logic        firmware_jumper_state,
  input wire logic        firmware_primary_sel,
  input wire logic [1:0]  serial_line_mode,
  input wire logic        sys_reset_req,
  input wire logic        fan_tach,
  input wire logic        fan_irq,
  input wire logic        irq
);
  // accepted address phase and the register index it names
  wire         acc   = hsel && htrans == HTRANS_NONSEQ && hready && hce;
  wire  [11:0] aidx  = haddr[IDX_MSB:IDX_LSB];
  logic        rpend_q;
  logic        wpend_q;
  logic [11:0] ridx_q;
  wire         rdone = rpend_q && hreadyout;
  wire         is_spc = ridx_q == IDX_SPC ||
                        ridx_q == IDX_SPC - ALT_BASE_DELTA;
  wire         is_fan = ridx_q == IDX_FAN;
  wire         is_ref = ridx_q == IDX_REFRESH;

  // track open data phases; a new accept wins over the close
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rpend_q <= 1'b0;
      wpend_q <= 1'b0;
      ridx_q  <= 12'h000;
    end else if (acc) begin
      rpend_q <= !hwrite;
      wpend_q <= hwrite;
      ridx_q  <= aidx;
    end else if (hreadyout) begin
      rpend_q <= 1'b0;
      wpend_q <= 1'b0;
    end
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_OKAY: assert property (hresp == 1'b0)
    else $error("slave answered other than okay");
  AST_WR_NOWAIT: assert property (acc && hwrite
    |=> hreadyout || !hce)
    else $error("write data phase was stretched");
  AST_RD_WAIT: assert property (acc && !hwrite && hce
    |=> !hreadyout ##1 (hreadyout || !$past(hce)))
    else $error("read did not take exactly one wait state");
  AST_SPC_FIELDS: assert property (rdone && is_spc |->
    hrdata[0] == 1'b0 && hrdata[7] == firmware_jumper_state &&
    hrdata[31:8] == 24'h000000)
    else $error("special control read-back fields wrong");
  AST_FAN_RSVD: assert property (rdone && is_fan
    |-> hrdata[6:1] == 6'h00)
    else $error("fan reserved bits read non-zero");
  AST_REFRESH_RD: assert property (rdone && is_ref
    |-> hrdata == RDATA_ZERO)
    else $error("refresh register read non-zero");
  AST_FAN_CLR: assert property ($rose(fan_tach) && fan_irq
    |-> ##[1:3] !fan_irq)
    else $error("fan interrupt held after a tach edge");
  AST_RST_FALL: assert property ($fell(sys_reset_req)
    |-> $past(wpend_q))
    else $error("reset request dropped without a write");
endmodule

bind bcw_board_ctrl bcw_board_ctrl_sva #(
  .WDOG_CYCLES_P(WDOG_CYCLES_P),
  .FAN_CYCLES_P (FAN_CYCLES_P)
) i_bcw_board_ctrl_sva (
  .hclk(hclk), .hresetn(hresetn), .hce(hce), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .firmware_jumper_state(firmware_jumper_state),
  .firmware_primary_sel(firmware_primary_sel),
  .serial_line_mode(serial_line_mode), .sys_reset_req(sys_reset_req),
  .fan_tach(fan_tach), .fan_irq(fan_irq), .irq(irq)
);

/* File: dv/bcw_board_ctrl_tb_top.sv */
// self-checking bench for the board control bank over ahb-lite.
// assumes short watchdog and fan counts set through the parameters.
`timescale 1ns/1ps
module bcw_board_ctrl_tb_top import bcw_pkg::*;;
  localparam int unsigned WD_P  = 64;
  localparam int unsigned FAN_P = 32;
  logic        hclk = 1'b0;
  logic        hresetn, hce, hsel, hwrite, jmp, fan_tach, fan_run;
  logic [31:0] haddr, hwdata, rd_val;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  tach_cnt;
  wire         hready, hreadyout, hresp, prim_sel, sys_rst, fan_irq, irq;
  wire  [31:0] hrdata;
  wire  [1:0]  line_mode;
  int          n_fail, cmp_count;

  // 40 mhz clock and a single slave, so hready is its own hreadyout
  always #12.5 hclk = ~hclk;
  assign hready = hreadyout;

  bcw_board_ctrl #(.WDOG_CYCLES_P(WD_P), .FAN_CYCLES_P(FAN_P))
  i_bcw_board_ctrl (
    .hclk(hclk), .hresetn(hresetn), .hce(hce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .firmware_jumper_state(jmp), .firmware_primary_sel(prim_sel),
    .serial_line_mode(line_mode), .sys_reset_req(sys_rst),
    .fan_tach(fan_tach), .fan_irq(fan_irq), .irq(irq));

  // tach period of 16 cycles, well inside the slow limit; stops in place
  always @(posedge hclk) begin
    if (fan_run) begin
      tach_cnt <= tach_cnt + 4'h1;
      fan_tach <= tach_cnt[3];
    end
  end

  task automatic give_verdict;
    $display("compares %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // pins are sampled mid-cycle so the last edge's updates have landed
  task automatic chkp(input int which, input logic [1:0] pin_exp);
    @(negedge hclk);
    case (which)
      0: chk(32'(prim_sel), 32'(pin_exp));
      1: chk(32'(sys_rst), 32'(pin_exp));
      2: chk(32'(fan_irq), 32'(pin_exp));
      3: chk(32'(irq), 32'(pin_exp));
      default: chk(32'(line_mode), 32'(pin_exp));
    endcase
    @(posedge hclk);
  endtask

  // bounded wait for hready sampled high at a rising edge
  task automatic wait_rdy;
    for (int i = 0; i < 16; i++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) return;
    end
    n_fail++;
    $display("[ERR] t=%0t seen=%h exp=%h", $time, 1'b0, 1'b1);
    give_verdict();
  endtask

  // one single word transfer: address phase, then data phase
  task automatic xfer(input logic w, input logic [11:0] idx,
                      input logic [7:0] wd);
    hsel   <= 1'b1;
    haddr  <= {18'h00000, idx, 2'h0};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, wd};
    wait_rdy();
    rd_val = hrdata;
  endtask

  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d);
  endtask

  task automatic rd_chk(input logic [11:0] idx, input logic [7:0] exp);
    xfer(1'b0, idx, 8'h00);
    chk(rd_val, {24'h000000, exp});
  endtask

  // hang guard
  initial begin
    repeat (20000) @(posedge hclk);
    n_fail++;
    $display("[ERR] t=%0t seen=%h exp=%h", $time, 1'b0, 1'b1);
    give_verdict();
  end

  initial begin
    {hresetn, hsel, hwrite, fan_tach} = 4'h0;
    {hce, jmp, fan_run} = 3'h7;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    htrans = 2'h0;
    hsize = 3'h2;
    tach_cnt = 4'h0;
    n_fail = 0;
    cmp_count = 0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk(IDX_SPC, 8'hA0);
    rd_chk(IDX_FAN, 8'h00);
    rd_chk(IDX_ISTAT, 8'h00);
    chkp(1, 2'h0);
    chkp(4, 2'h0);
    $display("reset values done");
    for (int k = 0; k < 8; k++) begin
      jmp <= k[2];
      wr(IDX_SPC, {1'b0, k[1], k[0], 5'h00});
      chkp(0, 2'(k[1] ? k[0] : k[2]));
      rd_chk(IDX_SPC, {k[2], k[1], k[0], 5'h00});
    end
    $display("firmware select done");
    for (int m = 0; m < 4; m++) begin
      wr(IDX_SPC - ALT_BASE_DELTA, {3'b001, 2'(m), 3'b001});
      chkp(4, 2'(m));
      rd_chk(IDX_SPC, {3'b101, 2'(m), 3'b000});
    end
    $display("line mode done");
    wr(IDX_IMASK, 8'h03);
    wr(IDX_SPC, 8'h22);
    for (int r = 0; r < 4; r++) begin
      repeat (40) @(posedge hclk);
      wr(IDX_REFRESH, REFRESH_KEY);
    end
    chkp(1, 2'h0);
    repeat (40) @(posedge hclk);
    wr(IDX_REFRESH, 8'h33);
    repeat (30) @(posedge hclk);
    chkp(1, 2'h1);
    rd_chk(IDX_SPC, 8'hA6);
    rd_chk(IDX_ISTAT, 8'h01);
    chkp(3, 2'h1);
    wr(IDX_REFRESH, REFRESH_KEY);
    chkp(1, 2'h0);
    rd_chk(IDX_SPC, 8'hA2);
    wr(IDX_ISTAT, 8'h01);
    chkp(3, 2'h0);
    wr(IDX_SPC, 8'h20);
    repeat (100) @(posedge hclk);
    chkp(1, 2'h0);
    rd_chk(IDX_SPC, 8'hA0);
    $display("watchdog done");
    wr(IDX_FAN, 8'hFF);
    rd_chk(IDX_FAN, 8'h01);
    fan_run <= 1'b0;
    repeat (50) @(posedge hclk);
    chkp(2, 2'h1);
    rd_chk(IDX_FAN, 8'h81);
    rd_chk(IDX_ISTAT, 8'h02);
    chkp(3, 2'h1);
    wr(IDX_FAN, 8'h00);
    chkp(2, 2'h0);
    wr(IDX_FAN, 8'h7F);
    chkp(2, 2'h1);
    wr(IDX_IMASK, 8'h00);
    chkp(3, 2'h0);
    fan_run <= 1'b1;
    repeat (20) @(posedge hclk);
    chkp(2, 2'h0);
    wr(IDX_ISTAT, 8'h03);
    rd_chk(IDX_ISTAT, 8'h00);
    $display("fan monitor done");
    rd_chk(12'hCA5, 8'h00);
    wr(12'hCA5, 8'hFF);
    rd_chk(IDX_REFRESH, 8'h00);
    rd_chk(IDX_FAN - ALT_BASE_DELTA, 8'h01);
    $display("decode done");
    // a low clock enable must hold the watchdog count in place
    wr(IDX_SPC, 8'h22);
    hce <= 1'b0;
    repeat (100) @(posedge hclk);
    hce <= 1'b1;
    chkp(1, 2'h0);
    repeat (80) @(posedge hclk);
    chkp(1, 2'h1);
    $display("clock enable done");
    give_verdict();
  end
endmodule
